/* logic/rfm_pkg.sv */
package rfm_pkg;

  // =========================================
  // widths and spaces
  localparam int unsigned NUM_SPACES   = 3;
  localparam int unsigned ADDR_W       = 26;   // 64 Mbyte per space
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned WS_W         = 4;
  localparam int unsigned BURST_BEATS  = 4;    // cache line refill beats
  localparam int unsigned BEAT_W       = 2;

  // =========================================
  // bus width codes
  localparam logic [1:0] WIDTH_8  = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;

  // =========================================
  // access mode codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_FAST   = 2'h1;

  // =========================================
  // timing: isa-like cycle, 100 ns clock
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned ISA_SETUP_NS    = 100;
  localparam int unsigned ISA_STROBE_NS   = 500;
  localparam int unsigned ISA_RECOVER_NS  = 100;
  localparam int unsigned ISA_SETUP_CYC   =
    (ISA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ISA_STROBE_CYC  =
    (ISA_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ISA_RECOVER_CYC =
    (ISA_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 4;

  // =========================================
  // reset values
  localparam logic [WS_W-1:0] WS_RESET = 4'h0;

  // =========================================
  // carriers
  typedef struct packed {
    logic [1:0]      width;
    logic [1:0]      mode;
    logic            wprot;
    logic [WS_W-1:0] wait_st;
  } rfm_space_cfg_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic              burst;
    logic [1:0]        space;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rfm_req_t;

  typedef struct packed {
    logic [NUM_SPACES-1:0] cs_n;
    logic [1:0]            card_cs_n;
    logic                  rd_n;
    logic                  wr_n;
    logic [ADDR_W-1:0]     addr;
  } rfm_pins_t;

endpackage

/* logic/rfm_wait_cnt.sv */
`timescale 1ns/1ps
// loadable down counter used for every phase length of the sequencer
module rfm_wait_cnt (
  input  wire logic                      core_clk_i,
  input  wire logic                      nrst_i,
  input  wire logic                      load_i,
  input  wire logic [rfm_pkg::CNT_W-1:0] value_i,
  output logic                           zero_o
);

  logic [rfm_pkg::CNT_W-1:0] cnt_r;

  assign zero_o = (cnt_r == '0);

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      cnt_r <= '0;
    else if (load_i)
      cnt_r <= value_i;
    else if (!zero_o)
      cnt_r <= cnt_r - 1'b1;
  end

endmodule // rfm_wait_cnt

/* logic/rfm_seq.sv */
`timescale 1ns/1ps
module rfm_seq (
  input  wire logic                           core_clk_i,
  input  wire logic                           nrst_i,
  input  rfm_pkg::rfm_req_t                   req_i,
  input  rfm_pkg::rfm_space_cfg_t [2:0]       space_cfg_i,
  input  wire logic                           redirect_strap_i,
  input  wire logic                           redirect_sw_i,
  input  wire logic                           gfx_en_i,
  input  wire logic [rfm_pkg::DATA_W-1:0]     mem_rdata_i,
  output logic                                req_ready_o,
  output logic                                done_o,
  output logic                                beat_o,
  output logic                                wr_blocked_o,
  output logic                                gfx_avail_o,
  output logic [rfm_pkg::DATA_W-1:0]          rdata_o,
  output rfm_pkg::rfm_pins_t                  pins_o,
  output logic [rfm_pkg::DATA_W-1:0]          mem_wdata_o,
  output logic                                mem_wdata_oe_o
);

  // =========================================
  // state
  typedef enum logic [2:0] {
    RFM_IDLE,
    RFM_SETUP,
    RFM_STROBE,
    RFM_RECOVER
  } rfm_state_t;

  rfm_state_t                   state_r;
  rfm_state_t                   state_nxt;
  rfm_pkg::rfm_req_t            cur_r;
  logic                         burst_r;
  logic                         blocked_r;
  logic [rfm_pkg::BEAT_W-1:0]   beat_r;
  logic                         strap_r;
  logic                         strap_taken_r;
  logic                         req_ready_r;
  logic                         done_r;
  logic                         beat_pulse_r;
  logic                         gfx_avail_r;
  logic [rfm_pkg::DATA_W-1:0]   rdata_r;
  rfm_pkg::rfm_pins_t           pins_r;
  logic [rfm_pkg::DATA_W-1:0]   wdata_r;
  logic                         wdata_oe_r;

  // =========================================
  // decode
  rfm_pkg::rfm_space_cfg_t      cfg_cur;
  rfm_pkg::rfm_space_cfg_t      cfg_new;
  logic                         any_32bit;
  logic                         width_bad;
  logic                         new_burst_ok;
  logic                         new_blocked;
  logic                         is_fast;
  logic                         redirect;
  logic                         cnt_load;
  logic [rfm_pkg::CNT_W-1:0]    cnt_value;
  logic                         cnt_zero;
  logic                         last_beat;
  logic                         start;
  logic [rfm_pkg::CNT_W:0]      isa_strobe_sum;
  logic [rfm_pkg::CNT_W-1:0]    isa_strobe_cnt;

  // space index 3 is never decoded; it is treated as space 2
  wire [1:0] cur_sp = (cur_r.space > 2'h2) ? 2'h2 : cur_r.space;
  wire [1:0] new_sp = (req_i.space > 2'h2) ? 2'h2 : req_i.space;

  assign cfg_cur = space_cfg_i[cur_sp];
  assign cfg_new = space_cfg_i[new_sp];

  // a 32-bit space takes away the graphics path
  assign any_32bit = (space_cfg_i[0].width == rfm_pkg::WIDTH_32)
                   | (space_cfg_i[1].width == rfm_pkg::WIDTH_32)
                   | (space_cfg_i[2].width == rfm_pkg::WIDTH_32);
  // with graphics on, a 32-bit target is refused outright
  assign width_bad = gfx_en_i && (cfg_new.width == rfm_pkg::WIDTH_32);

  // page-mode burst only for wide fast spaces
  assign new_burst_ok = req_i.burst && !req_i.write
                      && (cfg_new.mode == rfm_pkg::MODE_FAST)
                      && (cfg_new.width != rfm_pkg::WIDTH_8);
  assign new_blocked  = req_i.write && cfg_new.wprot;
  assign start        = req_i.valid && req_ready_r && (state_r == RFM_IDLE);

  assign is_fast   = (cfg_cur.mode == rfm_pkg::MODE_FAST) || burst_r;
  assign last_beat = !burst_r || (beat_r == rfm_pkg::BEAT_W'(rfm_pkg::BURST_BEATS - 1));
  // strap caught after reset release, software may also ask
  assign redirect  = strap_r | redirect_sw_i;

  // normal strobe plus waits; a long wait clips at the counter top
  // rather than wrapping round to a one-cycle strobe
  assign isa_strobe_sum = {1'b0, rfm_pkg::CNT_W'(rfm_pkg::ISA_STROBE_CYC - 1)}
                        + {1'b0, cfg_cur.wait_st};
  assign isa_strobe_cnt = isa_strobe_sum[rfm_pkg::CNT_W] ? '1
                        : isa_strobe_sum[rfm_pkg::CNT_W-1:0];

  // =========================================
  // sequencer
  always_comb
  begin
    state_nxt = state_r;
    cnt_load  = 1'b0;
    cnt_value = '0;
    case (state_r)
      RFM_IDLE:
      begin
        if (start && !width_bad)
        begin
          state_nxt = RFM_SETUP;
          cnt_load  = 1'b1;
          // fast/burst load no setup count; normal loads ISA_SETUP_CYC - 1, which is also 0
          cnt_value = (cfg_new.mode == rfm_pkg::MODE_FAST || new_burst_ok)
                    ? '0 : rfm_pkg::CNT_W'(rfm_pkg::ISA_SETUP_CYC - 1);
        end
      end
      RFM_SETUP:
      begin
        if (cnt_zero)
        begin
          state_nxt = RFM_STROBE;
          cnt_load  = 1'b1;
          // isa strobe length plus programmed waits
          // fast and burst beats run at clock rate plus waits
          cnt_value = is_fast ? cfg_cur.wait_st
                    : isa_strobe_cnt;
        end
      end
      RFM_STROBE:
      begin
        if (cnt_zero)
        begin
          cnt_load = 1'b1;
          if (!last_beat)
          begin
            // next page beat keeps select low, waits again
            state_nxt = RFM_STROBE;
            cnt_value = cfg_cur.wait_st;
          end
          else if (is_fast)
            state_nxt = RFM_IDLE;
          else
          begin
            state_nxt = RFM_RECOVER;
            cnt_value = rfm_pkg::CNT_W'(rfm_pkg::ISA_RECOVER_CYC - 1);
          end
        end
      end
      RFM_RECOVER:
      begin
        if (cnt_zero)
          state_nxt = RFM_IDLE;
      end
      default:
        state_nxt = RFM_IDLE;
    endcase
  end

  rfm_wait_cnt u_wait (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .load_i     (cnt_load),
    .value_i    (cnt_value),
    .zero_o     (cnt_zero)
  );

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_r       <= RFM_IDLE;
      strap_r       <= 1'b0;
      strap_taken_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (!strap_taken_r)
      begin
        strap_r       <= redirect_strap_i;
        strap_taken_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cur_r     <= '0;
      burst_r   <= 1'b0;
      blocked_r <= 1'b0;
      beat_r    <= '0;
    end
    else if (start)
    begin
      cur_r     <= req_i;
      burst_r   <= new_burst_ok;
      blocked_r <= new_blocked;
      beat_r    <= '0;
    end
    else if (state_r == RFM_STROBE && cnt_zero && !last_beat)
    begin
      beat_r     <= beat_r + 1'b1;
      cur_r.addr <= cur_r.addr + rfm_pkg::ADDR_W'(cfg_cur.width == rfm_pkg::WIDTH_32 ? 4 : 2);
    end
  end

  // =========================================
  // pins: separate read and write strobes
  wire in_cycle  = (state_nxt == RFM_SETUP) || (state_nxt == RFM_STROBE);
  wire strobe_on = (state_nxt == RFM_STROBE);
  wire [1:0] tgt = start ? new_sp : cur_sp;
  wire tgt_wr    = start ? req_i.write : cur_r.write;
  wire tgt_blk   = start ? new_blocked : blocked_r;
  // byte lanes above the space width are left at zero
  wire [1:0] tgt_w = start ? cfg_new.width : cfg_cur.width;
  wire [rfm_pkg::DATA_W-1:0] wd_src = start ? req_i.wdata : cur_r.wdata;
  wire [rfm_pkg::DATA_W-1:0] lane_mask =
    (tgt_w == rfm_pkg::WIDTH_8)  ? 32'h0000_00ff :
    (tgt_w == rfm_pkg::WIDTH_16) ? 32'h0000_ffff : 32'hffff_ffff;

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pins_r     <= '{cs_n: 3'h7, card_cs_n: 2'h3, rd_n: 1'b1, wr_n: 1'b1, addr: '0};
      wdata_r    <= '0;
      wdata_oe_r <= 1'b0;
    end
    else
    begin
      // chip selects 1 and 2 move to the card socket when redirected
      pins_r.cs_n[0]      <= !(in_cycle && tgt == 2'h0);
      pins_r.cs_n[1]      <= !(in_cycle && tgt == 2'h1 && !redirect);
      pins_r.cs_n[2]      <= !(in_cycle && tgt == 2'h2 && !redirect);
      pins_r.card_cs_n[0] <= !(in_cycle && tgt == 2'h1 && redirect);
      pins_r.card_cs_n[1] <= !(in_cycle && tgt == 2'h2 && redirect);
      pins_r.rd_n         <= !(strobe_on && !tgt_wr);
      // a protected write never strobes
      pins_r.wr_n         <= !(strobe_on && tgt_wr && !tgt_blk);
      pins_r.addr         <= (state_nxt == RFM_STROBE && state_r == RFM_STROBE && cnt_zero)
                           ? cur_r.addr + rfm_pkg::ADDR_W'(tgt_w == rfm_pkg::WIDTH_32 ? 4 : 2)
                           : (start ? req_i.addr : cur_r.addr);
      wdata_r             <= wd_src & lane_mask;
      wdata_oe_r          <= in_cycle && tgt_wr && !tgt_blk;
    end
  end

  // =========================================
  // cpu side handshake; no shared dram state, so graphics runs alongside
  wire beat_end = (state_r == RFM_STROBE) && cnt_zero;

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      req_ready_r  <= 1'b0;
      done_r       <= 1'b0;
      beat_pulse_r <= 1'b0;
      wr_blocked_o <= 1'b0;
      gfx_avail_r  <= 1'b0;
      rdata_r      <= '0;
    end
    else
    begin
      req_ready_r  <= (state_nxt == RFM_IDLE) && !start;
      done_r       <= (beat_end && last_beat) || (start && width_bad);
      beat_pulse_r <= beat_end && !cur_r.write;
      wr_blocked_o <= start && (new_blocked || width_bad);
      gfx_avail_r  <= !any_32bit;
      if (beat_end && !cur_r.write)
        rdata_r <= mem_rdata_i & lane_mask;
    end
  end

  assign req_ready_o    = req_ready_r;
  assign done_o         = done_r;
  assign beat_o         = beat_pulse_r;
  assign gfx_avail_o    = gfx_avail_r;
  assign rdata_o        = rdata_r;
  assign pins_o         = pins_r;
  assign mem_wdata_o    = wdata_r;
  assign mem_wdata_oe_o = wdata_oe_r;

endmodule // rfm_seq

/* sim/rfm_seq_monitor.sv */
`timescale 1ns/1ps
module rfm_seq_monitor (
  input  wire logic                    core_clk_i,
  input  wire logic                    nrst_i,
  input  rfm_pkg::rfm_req_t            req_i,
  input  rfm_pkg::rfm_space_cfg_t [2:0] space_cfg_i,
  input  wire logic                    redirect_sw_i,
  input  wire logic                    gfx_en_i,
  input  wire logic                    req_ready_o,
  input  wire logic                    done_o,
  input  wire logic                    beat_o,
  input  wire logic                    wr_blocked_o,
  input  wire logic                    gfx_avail_o,
  input  rfm_pkg::rfm_pins_t           pins_o,
  input  wire logic                    mem_wdata_oe_o
);
  // =========================================
  // helpers
  wire [1:0] sp = (req_i.space == 2'h3) ? 2'h2 : req_i.space;
  rfm_pkg::rfm_space_cfg_t c;
  assign c = space_cfg_i[sp];
  wire tk = req_i.valid && req_ready_o;
  wire ref32 = gfx_en_i && (c.width == rfm_pkg::WIDTH_32);
  wire any32 = (space_cfg_i[0].width == rfm_pkg::WIDTH_32) ||
               (space_cfg_i[1].width == rfm_pkg::WIDTH_32) ||
               (space_cfg_i[2].width == rfm_pkg::WIDTH_32);
  wire fst = tk && !ref32 && !req_i.burst && (c.mode == rfm_pkg::MODE_FAST);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // =========================================
  // properties
  a_ready_drops: assert property (tk |=> !req_ready_o)
    else $error("ready stayed high after a take");
  a_gfx_report: assert property (1 |=> gfx_avail_o == !$past(any32))
    else $error("graphics availability wrong");
  a_refuse_wide: assert property (tk && ref32 |=> wr_blocked_o && (&pins_o.cs_n))
    else $error("wide target not refused");
  a_prot_silent: assert property (tk && req_i.write && c.wprot && !ref32 |=>
    wr_blocked_o && pins_o.wr_n ##1 pins_o.wr_n [*7])
    else $error("protected write strobed");
  a_fast_read: assert property (fst && !req_i.write && c.wait_st == 4'h0 |->
    ##2 !pins_o.rd_n ##1 done_o && beat_o && pins_o.rd_n)
    else $error("fast read timing wrong");
  a_fast_write: assert property (fst && req_i.write && !c.wprot && c.wait_st == 4'h0 |->
    ##2 !pins_o.wr_n && mem_wdata_oe_o ##1 done_o)
    else $error("fast write timing wrong");
  a_isa_strobe: assert property (tk && !ref32 && !req_i.write && c.wait_st == 4'h0 &&
    c.mode == rfm_pkg::MODE_NORMAL |-> ##1 pins_o.rd_n ##1 !pins_o.rd_n [*5]
    ##1 pins_o.rd_n)
    else $error("normal read strobe length wrong");
  a_wait_stretch: assert property (fst && !req_i.write && c.wait_st == 4'h2 |->
    ##2 !pins_o.rd_n [*3] ##1 pins_o.rd_n && done_o)
    else $error("wait states not inserted");
  a_strobe_excl: assert property (pins_o.rd_n || pins_o.wr_n)
    else $error("read and write strobes together");
  a_one_select: assert property ($onehot0(~{pins_o.cs_n, pins_o.card_cs_n}))
    else $error("two selects active");
  a_card_remap: assert property (redirect_sw_i |-> pins_o.cs_n[2:1] == 2'h3)
    else $error("redirected select still on memory");
endmodule // rfm_seq_monitor

bind rfm_seq rfm_seq_monitor rfm_seq_monitor_inst (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .req_i(req_i), .space_cfg_i(space_cfg_i),
  .redirect_sw_i(redirect_sw_i), .gfx_en_i(gfx_en_i), .req_ready_o(req_ready_o),
  .done_o(done_o), .beat_o(beat_o), .wr_blocked_o(wr_blocked_o),
  .gfx_avail_o(gfx_avail_o), .pins_o(pins_o), .mem_wdata_oe_o(mem_wdata_oe_o));

/* sim/rfm_mem_model.sv */
`timescale 1ns/1ps
module rfm_mem_model (
  input  wire logic                  core_clk_i,
  input  rfm_pkg::rfm_pins_t         pins_i,
  output logic [rfm_pkg::DATA_W-1:0] rdata_o
);
  // undriven bus flips every cycle so a read taken outside the strobe shows up
  logic [31:0] junk_r = 32'h5a5a_0f0f;
  always @(posedge core_clk_i) junk_r <= ~junk_r;
  wire sel = !(&{pins_i.cs_n, pins_i.card_cs_n});
  assign rdata_o = (sel && !pins_i.rd_n) ? ({6'h0, pins_i.addr} ^ 32'ha5a5_a5a5) : junk_r;
endmodule // rfm_mem_model

/* sim/rfm_seq_tb.sv */
`timescale 1ns/1ps
module rfm_seq_tb;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic strap = 1'b0, sw = 1'b0, gfx = 1'b0;
  rfm_pkg::rfm_req_t req = '0;
  rfm_pkg::rfm_space_cfg_t [2:0] cfg;
  rfm_pkg::rfm_pins_t pins;
  wire [31:0] mrd, rdata, wd;
  wire ready, done, beat, wb, gav, woe;
  int num_errors = 0, num_checks = 0, cyc = 0;
  int nbeat, nwr, nrd, nsel, ncs1, ncard, nwb, noe;
  logic [31:0] last, lastw;

  rfm_seq rfm_seq_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .req_i(req),
    .space_cfg_i(cfg), .redirect_strap_i(strap), .redirect_sw_i(sw), .gfx_en_i(gfx),
    .mem_rdata_i(mrd), .req_ready_o(ready), .done_o(done), .beat_o(beat),
    .wr_blocked_o(wb), .gfx_avail_o(gav), .rdata_o(rdata), .pins_o(pins),
    .mem_wdata_o(wd), .mem_wdata_oe_o(woe));
  rfm_mem_model rfm_mem_model_inst (.core_clk_i(core_clk_i), .pins_i(pins), .rdata_o(mrd));

  always #50 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  // =========================================
  // shared tasks
  task automatic wrap_up;
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  function automatic logic [31:0] ev(input logic [25:0] a, input logic [31:0] m);
    return ({6'h0, a} ^ 32'ha5a5_a5a5) & m;
  endfunction

  // one request, then watch the pins at each falling edge until done or 60 cycles
  task automatic xfer(input logic w, input logic b, input logic [1:0] s, input logic [25:0] a);
    int i;
    i = 0;
    {nbeat, nwr, nrd, nsel, ncs1, ncard, nwb, noe} = '0;
    last = 'x;
    lastw = 'x;
    @(posedge core_clk_i);
    req <= '{1'b1, w, b, s, a, 32'hc3c3_5a5a};
    // ready settles by the falling edge and holds up to the rising edge that takes
    do @(negedge core_clk_i); while (ready !== 1'b1);
    @(posedge core_clk_i);
    req.valid <= 1'b0;
    // first look is in the cycle after the take edge: refusals and flags pulse there
    do
    begin
      @(negedge core_clk_i);
      i++;
      noe += (woe === 1'b1);
      if (pins.wr_n === 1'b0)
        lastw = wd;
      nbeat += (beat === 1'b1);
      nwr += (pins.wr_n === 1'b0);
      nrd += (pins.rd_n === 1'b0);
      nsel += (pins.cs_n !== 3'h7);
      ncs1 += (pins.cs_n[1] === 1'b0);
      ncard += (pins.card_cs_n !== 2'h3);
      nwb += (wb === 1'b1);
      if (beat === 1'b1)
        last = rdata;
    end
    while (done !== 1'b1 && i < 60);
    chk("done", i < 60, 1);
  endtask

  // =========================================
  // scenarios
  task automatic t_widths;
    xfer(0, 0, 2'h0, 26'h012_3456);
    chk("rd16", last, ev(26'h012_3456, 32'h0000_ffff));
    chk("beats1", nbeat, 1);
    xfer(0, 0, 2'h1, 26'h3ff_fffe);
    chk("rd8", last, ev(26'h3ff_fffe, 32'h0000_00ff));
    chk("isa_len", nrd, rfm_pkg::ISA_STROBE_CYC);
    xfer(1, 0, 2'h0, 26'h100);
    chk("wr_open", nwr != 0, 1);
    chk("wd16", lastw, 32'h0000_5a5a);
    chk("oe_open", noe != 0, 1);
  endtask

  task automatic t_burst;
    xfer(0, 1, 2'h0, 26'h40);
    chk("burst16", nbeat, rfm_pkg::BURST_BEATS);
    chk("b16_last", last, ev(26'h46, 32'h0000_ffff));
    xfer(0, 1, 2'h2, 26'h40);
    chk("burst32", nbeat, rfm_pkg::BURST_BEATS);
    chk("b32_last", last, ev(26'h4c, 32'hffff_ffff));
    xfer(0, 1, 2'h1, 26'h40);
    chk("burst8", nbeat, 1);
  endtask

  task automatic t_protect;
    xfer(1, 0, 2'h2, 26'h80);
    chk("wr_prot", nwr, 0);
    chk("wr_flag", nwb, 1);
    chk("oe_prot", noe, 0);
  endtask

  task automatic t_waits;
    @(posedge core_clk_i);
    cfg[0].wait_st <= 4'h2;
    xfer(0, 0, 2'h0, 26'h222);
    chk("rd_ws2", nrd, 3);
    chk("rd_ws2d", last, ev(26'h222, 32'h0000_ffff));
  endtask

  task automatic t_redirect;
    @(posedge core_clk_i);
    sw <= 1'b1;
    xfer(0, 0, 2'h1, 26'h20);
    chk("cs1_quiet", ncs1, 0);
    chk("card_sel", ncard != 0, 1);
    @(posedge core_clk_i);
    sw <= 1'b0;
  endtask

  task automatic t_gfx;
    @(posedge core_clk_i);
    gfx <= 1'b1;
    #1;
    chk("gfx_off32", gav, 0);
    xfer(0, 0, 2'h3, 26'h80);
    chk("ref_sel", nsel, 0);
    chk("ref_flag", nwb, 1);
    @(posedge core_clk_i);
    cfg[2].width <= rfm_pkg::WIDTH_16;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk("gfx_on16", gav, 1);
    xfer(0, 0, 2'h0, 26'h9);
    chk("rd_gfx", last, ev(26'h9, 32'h0000_ffff));
  endtask

  // strap is only taken just after reset, so this scenario resets mid-run
  task automatic t_strap;
    @(posedge core_clk_i);
    strap <= 1'b1;
    nrst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    xfer(0, 0, 2'h2, 26'h30);
    chk("strap_cs2", nsel, 0);
    chk("strap_card", ncard != 0, 1);
    chk("strap_rd", last, ev(26'h30, 32'h0000_ffff));
  endtask

  initial
  begin
    cfg[0] = '{rfm_pkg::WIDTH_16, rfm_pkg::MODE_FAST, 1'b0, 4'h0};
    cfg[1] = '{rfm_pkg::WIDTH_8, rfm_pkg::MODE_NORMAL, 1'b0, 4'h0};
    cfg[2] = '{rfm_pkg::WIDTH_32, rfm_pkg::MODE_FAST, 1'b1, 4'h1};
    repeat (8) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    t_widths();
    t_burst();
    t_protect();
    t_waits();
    t_redirect();
    t_gfx();
    t_strap();
    wrap_up();
  end
endmodule // rfm_seq_tb
